// file: dmsu_data_memory.sv
// Purpose: banked data memory, pointers, table and flag registers of the core
// Assumes: core issues one access per cycle and waits while busy is high
// Notes: special area is common to all banks, general area is banked
`timescale 1ns/100ps
`include "dmsu_defines.svh"

// Function
// - data memory is 8 bits wide and starts at address 00h
// - unused special-area addresses read back as 00h
// - read-only special registers ignore writes; general area is read-write
// - single bits of any location can be set or cleared alone
// - indirect port accesses act on the location held by its pointer
// - port zero reaches bank 0 only; port one reaches the selected bank
// - direct addressing reaches bank 0; other banks only via port one
// - indirect access to an indirect port reads 00h, writes nothing
// - both pointers are real registers, readable, writable and modifiable
// - alu results go to the working register; memory moves pass through it
// - writing pc low byte replaces low byte only, staying in page
// - a pc low byte load inserts one dummy cycle
// - table pointers are read-write; table read fills the table high byte
// - flag register writes change only the arithmetic flags
// - halted flag cleared by power-up or kick, set by halt
// - watchdog flag cleared by power-up, kick or halt; set by timeout
// - carry set on add carry or no subtract borrow; rotates update it
// - half carry set on low nibble carry or no nibble borrow
// - zero flag set when the result is zero
// - signed wrap set when carry into msb differs from carry out
// - flags are never saved automatically on interrupt or call
// - bits 7 and 6 read zero; system flags zero after power-up
// - unused upper bits of the table high byte read as zero
// - each table read takes two instruction cycles
module dmsu_data_memory
  import dmsu_pkg::*;
#(
  parameter int BANKS = 2,
  parameter int PW = 14
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data access from the core
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [7:0] acc_addr,
  input wire logic wr_from_alu,
  input wire logic bit_set,
  input wire logic bit_clr,
  input wire logic [2:0] bit_idx,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy,
  // alu results and raw carries
  input wire logic [7:0] alu_result,
  input wire logic wreg_load,
  input wire logic arith_upd,
  input wire logic logic_upd,
  input wire logic rot_upd,
  input wire logic carry_out,
  input wire logic nibble_carry,
  input wire logic carry_into_msb,
  input wire logic rot_carry,
  // system events
  input wire logic wdt_timeout,
  input wire logic watchdog_kick_op,
  input wire logic halt_op,
  // program counter
  input wire logic [7:0] pc_low_now,
  output logic pc_low_load,
  output logic [7:0] pc_low_value,
  output logic dummy_cycle,
  // table read
  input wire logic tbl_start,
  input wire logic [7:0] tbl_dest,
  input wire logic [PW-1:0] prog_word,
  output logic prog_rd,
  output logic [15:0] prog_addr,
  // register views
  output logic [7:0] working_reg,
  output logic [7:0] core_flags
);
  // general area is 128 bytes in every bank, banks stacked in one array
  localparam int GP_DEPTH = 128;
  localparam int MEM_DEPTH = BANKS * GP_DEPTH;

  // control state of the access logic; flag register and table sequencer keep their own
  typedef struct packed {
    logic [7:0] pointer_zero;
    logic [7:0] pointer_one;
    logic [7:0] bank_select;
    logic [7:0] working_reg;
    logic [7:0] tbl_lo;
    logic [7:0] tbl_hi;
    logic [7:0] table_high_byte;
    logic [7:0] rd_data;
    logic rd_valid;
    logic pc_low_load;
    logic [7:0] pc_low_value;
    logic dummy_cycle;
    logic [7:0] tbl_dest;
    logic [7:0] core_flags;
  } dmsu_top_t;

  dmsu_top_t s;
  dmsu_top_t next_s;

  // general area storage, banks stacked
  logic [7:0] gp_mem [MEM_DEPTH];

  // flag traffic toward the flag register module
  dmsu_flag_if fi ();

  // table read sequencer answers
  logic tr_done;
  logic tr_busy;
  logic [PW-1:0] tr_word;

  // address resolution results
  logic is_ind;
  logic [7:0] tgt_off;
  logic [7:0] tgt_bank;
  logic self_ind;
  logic in_gp;
  logic bank_ok;
  logic [$clog2(MEM_DEPTH)-1:0] mem_idx;
  logic [7:0] rd_val;
  logic [7:0] wr_src;
  logic [7:0] wr_val;
  logic [7:0] bit_mask;
  logic do_rd;
  logic do_wr;
  logic tbl_wr;
  logic tbl_take;
  logic mem_we;
  logic [7:0] sfr_val;

  dmsu_table_read #(
    .PW(PW)
  ) u_table (
    .clk(clk),
    .rst_n(rst_n),
    .start(tbl_take),
    .tbl_addr({s.tbl_hi, s.tbl_lo}),
    .prog_word(prog_word),
    .prog_rd(prog_rd),
    .prog_addr(prog_addr),
    .done(tr_done),
    .word(tr_word),
    .busy(tr_busy)
  );

  dmsu_status_flags u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .fi(fi)
  );

  // requests are refused while a table read owns the memory
  assign do_rd = acc_rd && !tr_busy;
  assign do_wr = acc_wr && !tr_busy;
  assign tbl_wr = tr_done;

  // a table start is taken only while the sequencer is idle
  assign tbl_take = tbl_start && !tr_busy;

  // resolve the target location of the current access
  always_comb begin
    is_ind = 1'b0;
    tgt_bank = `DMSU_ZERO8;
    // a table store aims at its saved destination, with the pointers of this cycle
    tgt_off = tbl_wr ? s.tbl_dest : acc_addr;
    if (tgt_off == `DMSU_A_IND0) begin
      is_ind = 1'b1;
      tgt_off = s.pointer_zero;
    end else if (tgt_off == `DMSU_A_IND1) begin
      is_ind = 1'b1;
      tgt_bank = s.bank_select;
      tgt_off = s.pointer_one;
    end
    self_ind = is_ind && (tgt_off == `DMSU_A_IND0 || tgt_off == `DMSU_A_IND1);
    in_gp = (tgt_off >= `DMSU_GP_BASE);
    // banks beyond the configured count read zero and drop writes
    bank_ok = (32'(tgt_bank) < BANKS);
    mem_idx = ($clog2(MEM_DEPTH))'({tgt_bank, tgt_off[6:0]});
  end

  // special area read decode
  always_comb begin
    unique case (tgt_off)
      `DMSU_A_PTR0: sfr_val = s.pointer_zero;
      `DMSU_A_PTR1: sfr_val = s.pointer_one;
      `DMSU_A_BANK: sfr_val = s.bank_select;
      `DMSU_A_WREG: sfr_val = s.working_reg;
      // the pc low byte reads back the live counter of the core
      `DMSU_A_PCL: sfr_val = pc_low_now;
      `DMSU_A_TBLP: sfr_val = s.tbl_lo;
      `DMSU_A_TBHP: sfr_val = s.tbl_hi;
      `DMSU_A_TABLE_HIGH_BYTE: sfr_val = s.table_high_byte;
      `DMSU_A_FLAGS: sfr_val = {`DMSU_UNIMPL_FLAGS, fi.flags};
      default: sfr_val = `DMSU_ZERO8;
    endcase
  end

  // read value, then data for plain and bit writes
  always_comb begin
    if (self_ind) begin
      rd_val = `DMSU_ZERO8;
    end else if (in_gp) begin
      rd_val = bank_ok ? gp_mem[mem_idx] : `DMSU_ZERO8;
    end else begin
      rd_val = sfr_val;
    end
    // writes come from working register or alu
    wr_src = wr_from_alu ? alu_result : s.working_reg;
    // bit operations rewrite the value read from the same location
    bit_mask = 8'h01 << bit_idx;
    if (bit_set) begin
      wr_val = rd_val | bit_mask;
    end else if (bit_clr) begin
      wr_val = rd_val & ~bit_mask;
    end else begin
      wr_val = wr_src;
    end
    if (tbl_wr) begin
      wr_val = tr_word[7:0];
    end
  end

  // a write through a pointer aimed at a port is dropped here
  // general area write enable
  assign mem_we = (do_wr || tbl_wr) && in_gp && bank_ok && !self_ind;

  // general area storage, written in place
  always_ff @(posedge clk) begin
    if (mem_we) begin
      gp_mem[mem_idx] <= wr_val;
    end
  end

  // flag traffic toward the flag register
  always_comb begin
    // raw alu carries pass straight through
    fi.arith_upd = arith_upd;
    fi.logic_upd = logic_upd;
    fi.rot_upd = rot_upd;
    fi.carry_out = carry_out;
    fi.nibble_carry = nibble_carry;
    fi.carry_into_msb = carry_into_msb;
    fi.rot_carry = rot_carry;
    fi.result = alu_result;
    fi.sw_we = (do_wr || tbl_wr) && !in_gp && !self_ind && tgt_off == `DMSU_A_FLAGS;
    fi.sw_data = wr_val;
    fi.wdt_timeout = wdt_timeout;
    fi.kick = watchdog_kick_op;
    fi.halt = halt_op;
  end

  // next state of the special registers and answer path
  always_comb begin
    next_s = s;
    next_s.rd_valid = do_rd;
    // pc load and dummy slot are one-cycle pulses in a row
    next_s.pc_low_load = 1'b0;
    next_s.dummy_cycle = s.pc_low_load;
    // flag output is a registered copy, one cycle behind the flag register
    next_s.core_flags = {`DMSU_UNIMPL_FLAGS, next_flags_view()};
    if (do_rd) begin
      next_s.rd_data = rd_val;
    end
    if (wreg_load) begin
      next_s.working_reg = alu_result;
    end
    // destination is kept for the store cycle
    if (tbl_take) begin
      next_s.tbl_dest = tbl_dest;
    end
    // table store shares the write decode with core writes
    if ((do_wr || tbl_wr) && !in_gp && !self_ind) begin
      unique case (tgt_off)
        `DMSU_A_PTR0: next_s.pointer_zero = wr_val;
        `DMSU_A_PTR1: next_s.pointer_one = wr_val;
        `DMSU_A_BANK: next_s.bank_select = wr_val;
        `DMSU_A_WREG: next_s.working_reg = wr_val;
        `DMSU_A_PCL: begin
          next_s.pc_low_load = 1'b1;
          next_s.pc_low_value = wr_val;
        end
        `DMSU_A_TBLP: next_s.tbl_lo = wr_val;
        `DMSU_A_TBHP: next_s.tbl_hi = wr_val;
        default: next_s = next_s;
      endcase
    end
    if (tbl_wr) begin
      next_s.table_high_byte = 8'(tr_word[PW-1:8]);
    end
  end

  // current flag register contents as seen through the interface
  function automatic dmsu_flags_t next_flags_view();
    return fi.flags;
  endfunction

  // register all control state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pc_low_load = s.pc_low_load;
  assign pc_low_value = s.pc_low_value;
  assign dummy_cycle = s.dummy_cycle;

  // read answer
  assign rd_data = s.rd_data;
  assign rd_valid = s.rd_valid;

  assign busy = tr_busy;
  assign working_reg = s.working_reg;

  assign core_flags = s.core_flags;
endmodule

// file: dmsu_defines.svh
// Purpose: address map, bit positions and zero constants of the data memory block
// Assumes: 8-bit data memory, general area in the upper half of each bank
// Notes: included by the data memory, flag register and table read files of the block
`ifndef DMSU_DEFINES_SVH
`define DMSU_DEFINES_SVH
`define DMSU_A_IND0 8'h00
`define DMSU_A_PTR0 8'h01
`define DMSU_A_IND1 8'h02
`define DMSU_A_PTR1 8'h03
`define DMSU_A_BANK 8'h04
`define DMSU_A_WREG 8'h05
`define DMSU_A_PCL 8'h06
`define DMSU_A_TBLP 8'h07
`define DMSU_A_TBHP 8'h08
`define DMSU_A_TABLE_HIGH_BYTE 8'h09
`define DMSU_A_FLAGS 8'h0a
`define DMSU_GP_BASE 8'h80
`define DMSU_BIT_C 0
`define DMSU_BIT_AC 1
`define DMSU_BIT_Z 2
`define DMSU_BIT_OV 3
`define DMSU_ZERO8 8'h00
`define DMSU_UNIMPL_FLAGS 2'h0
`endif

// file: dmsu_pkg.sv
// Purpose: shared types of the data memory block
// Assumes: nothing beyond the defines header
// Notes: states carry no explicit codes
package dmsu_pkg;
  // table read sequencer states
  typedef enum logic [1:0] {TR_IDLE, TR_FETCH, TR_STORE} dmsu_tr_state_t;
  // arithmetic and system flags, msb first as they sit in the register
  typedef struct packed {
    logic watchdog_expired_flag;
    logic halted_flag;
    logic signed_wrap_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } dmsu_flags_t;
endpackage

// file: dmsu_flag_if.sv
// Purpose: carries flag updates from the access logic to the flag register
// Assumes: single clock domain
// Notes: raw carries come from the external alu
`timescale 1ns/100ps
interface dmsu_flag_if;
  import dmsu_pkg::*;
  logic arith_upd;
  logic logic_upd;
  logic rot_upd;
  logic carry_out;
  logic nibble_carry;
  logic carry_into_msb;
  logic rot_carry;
  logic [7:0] result;
  logic sw_we;
  logic [7:0] sw_data;
  logic wdt_timeout;
  logic kick;
  logic halt;
  dmsu_flags_t flags;
  modport core (output arith_upd, logic_upd, rot_upd, carry_out, nibble_carry,
    carry_into_msb, rot_carry, result, sw_we, sw_data, wdt_timeout, kick, halt,
    input flags);
  modport flags_side (input arith_upd, logic_upd, rot_upd, carry_out, nibble_carry,
    carry_into_msb, rot_carry, result, sw_we, sw_data, wdt_timeout, kick, halt,
    output flags);
endinterface

// file: dmsu_status_flags.sv
// Purpose: core flag register with arithmetic and system flag updates
// Assumes: alu reports raw carries, subtraction carry means no borrow
// Notes: system events outrank software writes, arithmetic outranks writes
`timescale 1ns/100ps
`include "dmsu_defines.svh"
module dmsu_status_flags
  import dmsu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // flag traffic
  dmsu_flag_if.flags_side fi
);
  dmsu_flags_t st;
  dmsu_flags_t next_st;

  // flag update priority network
  always_comb begin
    next_st = st;
    if (fi.sw_we) begin
      next_st.signed_wrap_flag = fi.sw_data[`DMSU_BIT_OV];
      next_st.zero = fi.sw_data[`DMSU_BIT_Z];
      next_st.half_carry_flag = fi.sw_data[`DMSU_BIT_AC];
      next_st.carry = fi.sw_data[`DMSU_BIT_C];
    end
    if (fi.arith_upd) begin
      next_st.carry = fi.carry_out;
      next_st.half_carry_flag = fi.nibble_carry;
      next_st.signed_wrap_flag = fi.carry_into_msb ^ fi.carry_out;
    end
    if (fi.rot_upd) begin
      next_st.carry = fi.rot_carry;
    end
    if (fi.arith_upd || fi.logic_upd) begin
      next_st.zero = (fi.result == `DMSU_ZERO8);
    end
    if (fi.kick) begin
      next_st.halted_flag = 1'b0;
    end else if (fi.halt) begin
      next_st.halted_flag = 1'b1;
    end
    if (fi.wdt_timeout) begin
      next_st.watchdog_expired_flag = 1'b1;
    end else if (fi.kick || fi.halt) begin
      next_st.watchdog_expired_flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fi.flags = st;
endmodule

// file: dmsu_table_read.sv
// Purpose: two-cycle table read sequencer
// Assumes: program memory answers one cycle after its read strobe
// Notes: caller holds off data accesses while busy
`timescale 1ns/100ps
`include "dmsu_defines.svh"
module dmsu_table_read
  import dmsu_pkg::*;
#(
  parameter int PW = 16
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [15:0] tbl_addr,
  // program memory
  input wire logic [PW-1:0] prog_word,
  output logic prog_rd,
  output logic [15:0] prog_addr,
  // result
  output logic done,
  output logic [PW-1:0] word,
  output logic busy
);
  typedef struct packed {
    dmsu_tr_state_t state;
    logic [15:0] addr;
    logic rd;
    logic done;
    logic busy;
  } dmsu_tr_t;
  dmsu_tr_t s;
  dmsu_tr_t next_s;

  always_comb begin
    next_s = s;
    unique case (s.state)
      TR_IDLE: begin
        if (start) begin
          next_s.state = TR_FETCH;
          next_s.addr = tbl_addr;
        end
      end
      TR_FETCH: next_s.state = TR_STORE;
      TR_STORE: next_s.state = TR_IDLE;
    endcase
    // strobes decoded from the next state so they leave straight from flops
    next_s.rd = (next_s.state == TR_FETCH);
    next_s.done = (next_s.state == TR_STORE);
    next_s.busy = (next_s.state != TR_IDLE);
  end

  // sequencer register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{TR_IDLE, 16'h0000, 1'b0, 1'b0, 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign prog_rd = s.rd;
  assign prog_addr = s.addr;
  assign done = s.done;
  assign word = prog_word;
  assign busy = s.busy;
endmodule

// file: dmsu_properties.sv
// Purpose: port timing and flag checks of the data memory block
// Assumes: one clock, synchronous active low reset
// Notes: bound to every data memory instance
`timescale 1ns/100ps
module dmsu_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // core requests
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [7:0] acc_addr,
  input wire logic wr_from_alu,
  input wire logic bit_set,
  input wire logic bit_clr,
  input wire logic [7:0] alu_result,
  input wire logic arith_upd,
  input wire logic logic_upd,
  input wire logic wdt_timeout,
  input wire logic watchdog_kick_op,
  input wire logic halt_op,
  input wire logic tbl_start,
  // design answers
  input wire logic rd_valid,
  input wire logic busy,
  input wire logic pc_low_load,
  input wire logic [7:0] pc_low_value,
  input wire logic dummy_cycle,
  input wire logic prog_rd,
  input wire logic [7:0] working_reg,
  input wire logic [7:0] core_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic pcw;
  logic tbs;
  // plain byte write to the pc low byte, and an accepted table start
  assign pcw = acc_wr && !busy && acc_addr == 8'h06 && !bit_set && !bit_clr;
  assign tbs = tbl_start && !busy;
  read_answer_a: assert property (acc_rd && !busy |=> rd_valid)
    else $error("read request not answered");
  valid_cause_a: assert property (rd_valid |-> $past(acc_rd && !busy))
    else $error("read answer without request");
  table_span_a: assert property (tbs |=> busy [*2] ##1 !busy)
    else $error("table read length wrong");
  fetch_strobe_a: assert property (tbs |=> prog_rd ##1 !prog_rd)
    else $error("program fetch strobe wrong");
  pc_load_a: assert property (pcw |=> pc_low_load &&
    pc_low_value == $past(wr_from_alu ? alu_result : working_reg))
    else $error("pc low byte load wrong");
  dummy_slot_a: assert property (pc_low_load |=> dummy_cycle)
    else $error("dummy cycle missing");
  flag_pad_a: assert property (core_flags[7:6] == 2'h0)
    else $error("unused flag bits not zero");
  zero_flag_a: assert property (logic_upd && !arith_upd && !acc_wr |->
    ##2 core_flags[2] == ($past(alu_result, 2) == 8'h00))
    else $error("zero flag wrong");
  halt_set_a: assert property (halt_op && !watchdog_kick_op |-> ##2 core_flags[4])
    else $error("halted flag not set");
  timeout_set_a: assert property (wdt_timeout |-> ##2 core_flags[5])
    else $error("watchdog flag not set");
  kick_clear_a: assert property (watchdog_kick_op && !wdt_timeout |->
    ##2 core_flags[5:4] == 2'h0)
    else $error("kick did not clear system flags");
  // main scenarios
  table_c: cover property (tbs);
  pc_c: cover property (pcw);
  halt_c: cover property (halt_op);
endmodule
bind dmsu_data_memory dmsu_properties u_props (.clk, .rst_n, .acc_rd, .acc_wr, .acc_addr,
  .wr_from_alu, .bit_set, .bit_clr, .alu_result, .arith_upd, .logic_upd, .wdt_timeout,
  .watchdog_kick_op, .halt_op, .tbl_start, .rd_valid, .busy, .pc_low_load, .pc_low_value,
  .dummy_cycle, .prog_rd, .working_reg, .core_flags);

// file: dmsu_prog_model.sv
// Purpose: program memory behind the table read port
// Assumes: word is wanted while the strobe is high and one cycle after
// Notes: outside a fetch the word toggles so stale data is never trusted
`timescale 1ns/100ps
module dmsu_prog_model #(
  parameter int PW = 14
)(
  // clock
  input wire logic clk,
  // fetch port
  input wire logic prog_rd,
  input wire logic [15:0] prog_addr,
  output logic [PW-1:0] prog_word
);
  logic rd_q = 1'h0;
  logic [PW-1:0] junk = '0;
  // remember the strobe, keep the idle pattern moving
  always @(posedge clk) begin
    rd_q <= prog_rd;
    junk <= ~junk;
  end
  // content is a fixed scramble of the address
  assign prog_word = (prog_rd || rd_q) ? PW'(prog_addr * 16'h9e37 ^ 16'h1b5a) : junk;
endmodule

// file: data_memory_status_unit_bench.sv
// Purpose: self-checking bench of the data memory block
// Assumes: inputs move 2 ns after each rising edge
// Notes: an int array model tracks memory and pointers, a separate int tracks flags
`timescale 1ns/100ps
module data_memory_status_unit_bench;
  logic clk = 1'h0, rst_n = 1'h0, acc_rd = 1'h0, acc_wr = 1'h0, wr_from_alu = 1'h0;
  logic bit_set = 1'h0, bit_clr = 1'h0, wreg_load = 1'h0, arith_upd = 1'h0, logic_upd = 1'h0;
  logic rot_upd = 1'h0, carry_out = 1'h0, nibble_carry = 1'h0, carry_into_msb = 1'h0;
  logic rot_carry = 1'h0, wdt_timeout = 1'h0, watchdog_kick_op = 1'h0, halt_op = 1'h0;
  logic tbl_start = 1'h0, rd_valid, busy, pc_low_load, dummy_cycle, prog_rd;
  logic [2:0] bit_idx = 3'h0;
  logic [7:0] acc_addr = 8'h00, alu_result = 8'h00, pc_low_now = 8'h3c, tbl_dest = 8'h00;
  logic [7:0] rd_data, pc_low_value, working_reg, core_flags;
  logic [13:0] prog_word;
  logic [15:0] prog_addr;
  int mismatches = 0, compares = 0, cycles = 0, seed = 32'h3d4c99b0, fl = 0;
  int m[0:767];
  always #25 clk = ~clk;
  dmsu_data_memory u_dut (.clk, .rst_n, .acc_rd, .acc_wr, .acc_addr, .wr_from_alu, .bit_set,
    .bit_clr, .bit_idx, .rd_data, .rd_valid, .busy, .alu_result, .wreg_load, .arith_upd,
    .logic_upd, .rot_upd, .carry_out, .nibble_carry, .carry_into_msb, .rot_carry, .wdt_timeout,
    .watchdog_kick_op, .halt_op, .pc_low_now, .pc_low_load, .pc_low_value, .dummy_cycle,
    .tbl_start, .tbl_dest, .prog_word, .prog_rd, .prog_addr, .working_reg, .core_flags);
  dmsu_prog_model u_prog (.clk, .prog_rd, .prog_addr, .prog_word);
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // model: special area at 512 up, general area at bank * 256
  function automatic int loc(int b, int a);
    return a < 128 ? 512 + a : b * 256 + a;
  endfunction
  function automatic int res(int a);
    int p;
    if (a != 0 && a != 2) return loc(0, a);
    p = a == 0 ? m[513] : m[515];
    if (p == 0 || p == 2) return -1;
    return loc(a == 0 ? 0 : m[516], p);
  endfunction
  function automatic logic [15:0] mrd(int a);
    int i;
    i = res(a);
    if (i < 0 || i > 522) return 16'h0000;
    if (i == 518) return pc_low_now;
    return i == 522 ? fl : m[i];
  endfunction
  function automatic void mwr(int a, int d);
    int i;
    i = res(a);
    if (i == 522) fl = (fl & 8'h30) | (d & 8'h0f);
    else if ((i >= 0 && i < 512) || (i > 512 && i < 521 && i != 514)) m[i] = d & 8'hff;
  endfunction
  // one request per call; signals stay until the next call
  task automatic req(logic r, logic w, logic [7:0] a, logic [7:0] d, logic [1:0] b = 2'h0,
    logic s = 1'h1);
    {acc_rd, acc_wr, bit_set, bit_clr, wr_from_alu} = {r, w, b, s};
    acc_addr = a;
    alu_result = d;
  endtask
  task automatic wr(int a, int d);
    req(1'h0, 1'h1, a[7:0], d[7:0]);
    mwr(a, d);
    tick();
  endtask
  task automatic rd(int a);
    req(1'h1, 1'h0, a[7:0], alu_result);
    tick();
    check("rd_valid", 16'h0001, rd_valid);
    check("rd_data", mrd(a), rd_data);
  endtask
  task automatic quiet();
    req(1'h0, 1'h0, acc_addr, alu_result);
    tick();
  endtask
  task automatic ev(logic [2:0] e);
    {wdt_timeout, watchdog_kick_op, halt_op} = e;
    if (e[2]) fl |= 32;
    else if (e[1:0] != 2'h0) fl &= ~32;
    if (e[1]) fl &= ~16;
    else if (e[0]) fl |= 16;
    tick();
    {wdt_timeout, watchdog_kick_op, halt_op} = 3'h0;
    tick(2);
    check("core_flags", 16'(fl), core_flags);
  endtask
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    int a;
    tick(12);
    rst_n = 1'h1;
    for (a = 1; a < 128; a++) rd(a);
    $display("test reset map done");
    for (int i = 0; i < 16; i++) begin
      a = 8'h80 | ($random(seed) & 127);
      wr(a, $random(seed));
      rd(a);
    end
    wr(9, 8'h5a);
    wr(8'h40, 8'h77);
    rd(9);
    rd(8'h40);
    for (int i = 0; i < 8; i++) begin
      wr(144 + i, $random(seed));
      req(1'h0, 1'h1, 144 + i, 8'h00, {i[0], ~i[0]});
      bit_idx = i[2:0];
      if (i[0]) m[144 + i] |= 1 << i;
      else m[144 + i] &= ~(1 << i);
      tick();
      rd(144 + i);
    end
    $display("test general area done");
    wr(1, 8'ha0);
    wr(0, 8'h11);
    rd(8'ha0);
    wr(4, 1);
    wr(3, 8'ha0);
    wr(2, 8'h22);
    rd(2);
    wr(4, 2);
    wr(2, 8'h44);
    rd(2);
    rd(8'ha0);
    wr(1, 2);
    wr(0, 8'h33);
    rd(0);
    wr(1, 8'hd0);
    rd(1);
    $display("test indirect done");
    quiet();
    alu_result = 8'h6b;
    wreg_load = 1'h1;
    tick();
    wreg_load = 1'h0;
    m[517] = 8'h6b;
    tick();
    check("working_reg", 16'h006b, working_reg);
    req(1'h0, 1'h1, 8'hb0, 8'h00, 2'h0, 1'h0);
    mwr(8'hb0, 8'h6b);
    tick();
    rd(8'hb0);
    wr(6, 8'h5e);
    check("pc_low_load", 16'h0001, pc_low_load);
    check("pc_low_value", 16'h005e, pc_low_value);
    quiet();
    check("dummy_cycle", 16'h0001, dummy_cycle);
    $display("test working and pc done");
    wr(10, 8'hff);
    quiet();
    rd(10);
    quiet();
    for (int e = 0; e < 8; e++) ev(e);
    wr(10, 8'h00);
    quiet();
    rd(10);
    quiet();
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      {carry_out, nibble_carry, carry_into_msb, rot_carry} = r[11:8];
      alu_result = i < 3 ? 8'h00 : r[7:0];
      {arith_upd, logic_upd, rot_upd} = 3'h1 << (i % 3);
      if (i % 3 == 0) fl = (fl & ~1) | r[8];
      if (i % 3 == 1) fl = (fl & ~4) | ((alu_result == 8'h00) << 2);
      if (i % 3 == 2) fl = (fl & 8'h30) | {r[9] ^ r[11], alu_result == 8'h00, r[10], r[11]};
      tick();
      {arith_upd, logic_upd, rot_upd} = 3'h0;
      tick(2);
      check("core_flags", 16'(fl), core_flags);
    end
    $display("test flags done");
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      wr(7, r[7:0]);
      wr(8, r[15:8]);
      quiet();
      w = r[15:0] * 16'h9e37 ^ 16'h1b5a;
      tbl_dest = i == 2 ? 8'h00 : 8'hc0 + i;
      tbl_start = 1'h1;
      tick();
      tbl_start = 1'h0;
      check("busy", 16'h0001, busy);
      check("prog_addr", r[15:0], prog_addr);
      check("prog_rd", 16'h0001, prog_rd);
      tick(2);
      check("busy", 16'h0000, busy);
      m[res(tbl_dest)] = w[7:0];
      m[521] = w[13:8];
      rd(tbl_dest);
      rd(9);
      quiet();
    end
    $display("test table read done");
    rst_n = 1'h0;
    tick(2);
    rst_n = 1'h1;
    m = '{default: 0};
    fl = 0;
    rd(3);
    rd(10);
    $display("test second reset done");
    finish_test();
  end
endmodule
